// ==== hw/prefetch_window_pkg.sv ====
// Purpose: Shared constants for the read prefetch window decoder
// Assumes: Byte offsets on an 8-bit register address, 32-bit data
// Notes:   Window 1 size field holds size bits 31:1, bit 0 is polarity
package prefetch_window_pkg;

	// Register bus and read address widths
	localparam int REG_AW = 8;
	localparam int REG_DW = 32;
	localparam int ADDR_W = 64;

	// Register byte offsets
	localparam logic [7:0] OFF_MODE    = 8'h40;
	localparam logic [7:0] OFF_W1_LO   = 8'h50;
	localparam logic [7:0] OFF_W1_HI   = 8'h54;
	localparam logic [7:0] OFF_W1_CTL  = 8'h58;
	localparam logic [7:0] OFF_W2_LO   = 8'h5C;
	localparam logic [7:0] OFF_W2_HI   = 8'h60;
	localparam logic [7:0] OFF_W2_SIZE = 8'h64;
	localparam logic [7:0] OFF_STATUS  = 8'h70;

	// Field positions
	localparam int MODE_LSB   = 4;
	localparam int MODE_MSB   = 7;
	localparam int W1_POL_BIT = 0;
	localparam int ST_OK_BIT  = 0;
	localparam int ST_W1_BIT  = 1;
	localparam int ST_W2_BIT  = 2;
	localparam int ST_CNT_LSB = 16;
	localparam int ST_CNT_MSB = 31;

	// Reset values
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [3:0]  RST_MODE = 4'h0;
	localparam logic [15:0] RST_CNT  = 16'h0000;

endpackage

// ==== hw/window_match.sv ====
// Purpose: Decide whether a 64-bit address lies inside one window
// Assumes: Size is a byte count up to just under 4 GB
// Notes:   Purely combinational, used twice by the decoder
`timescale 1ns/10ps
`default_nettype none

module window_match (
	// Address under test
	input  wire logic [63:0] addr,
	// Window description
	input  wire logic [63:0] base,
	input  wire logic [31:0] size,
	// Result
	output logic             hit
);

	logic [63:0] offset;

	// Inside when at or above base and below base plus size
	always_comb begin
		offset = addr - base;
		hit    = (addr >= base) && (offset < {32'h00000000, size});
	end

endmodule

`default_nettype wire

// ==== hw/read_prefetch_window_decode.sv ====
// Purpose: Two programmable windows that qualify reads for smart prefetch
// Assumes: Read requests come from logic on clk, one cycle pulse each
// Notes:   Decision appears one cycle after the request
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Window 1 base low word, reset zero
// - Window 1 base high word, reset zero
// - Window 1 size in bits 31:1
// - Polarity 0 bars reads inside window 1
// - Polarity 1 permits only window reads
// - Mode field at 40h gates prefetch
// - Window 2 base low word, reset zero
// - Window 2 base high word, reset zero
// - Window 2 size full word, reset zero
module read_prefetch_window_decode (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Memory read from the parallel bus side
	input  wire logic        rd_req,
	input  wire logic [63:0] rd_addr,
	// Decision to the prefetch engine
	output logic             dec_valid,
	output logic             dec_prefetch_ok,
	output logic             dec_window1_hit,
	output logic             dec_window2_hit,
	// Prefetch mode seen by the engine
	output logic      [3:0]  prefetch_mode,
	output logic             prefetch_active
);

	// Programmed state
	logic [31:0] w1_lo_r, w1_lo_nxt;
	logic [31:0] w1_hi_r, w1_hi_nxt;
	logic [31:0] w1_ctl_r, w1_ctl_nxt;
	logic [31:0] w2_lo_r, w2_lo_nxt;
	logic [31:0] w2_hi_r, w2_hi_nxt;
	logic [31:0] w2_size_r, w2_size_nxt;
	logic [3:0]  mode_r, mode_nxt;
	logic        active_r, active_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	// Decision state
	logic        valid_r, valid_nxt;
	logic        ok_r, ok_nxt;
	logic        hit1_r, hit1_nxt;
	logic        hit2_r, hit2_nxt;
	logic        last_ok_r, last_ok_nxt;
	logic        last_w1_r, last_w1_nxt;
	logic        last_w2_r, last_w2_nxt;
	logic [15:0] grant_cnt_r, grant_cnt_nxt;

	// Combinational helpers
	logic        hit1;
	logic        hit2;
	logic        w1_pol;
	logic        permit;
	logic [31:0] w1_size;

	// Window 1 size has two byte granularity
	assign w1_size = {w1_ctl_r[31:1], 1'b0};
	assign w1_pol  = w1_ctl_r[prefetch_window_pkg::W1_POL_BIT];

	// Window 1 compare
	window_match u_win1 (
		.addr (rd_addr),
		.base ({w1_hi_r, w1_lo_r}),
		.size (w1_size),
		.hit  (hit1)
	);

	// Window 2 compare
	window_match u_win2 (
		.addr (rd_addr),
		.base ({w2_hi_r, w2_lo_r}),
		.size (w2_size_r),
		.hit  (hit2)
	);

	// Permission from window hits and polarity
	always_comb begin
		if (w1_pol) begin
			permit = hit1 || hit2;
		end else begin
			permit = !hit1;
		end
	end

	// Register writes and read data
	always_comb begin
		w1_lo_nxt   = w1_lo_r;
		w1_hi_nxt   = w1_hi_r;
		w1_ctl_nxt  = w1_ctl_r;
		w2_lo_nxt   = w2_lo_r;
		w2_hi_nxt   = w2_hi_r;
		w2_size_nxt = w2_size_r;
		mode_nxt    = mode_r;
		rdata_nxt   = 32'h00000000;
		if (reg_wr) begin
			case (reg_addr)
				prefetch_window_pkg::OFF_MODE: begin
					mode_nxt = reg_wdata[prefetch_window_pkg::MODE_MSB:
						prefetch_window_pkg::MODE_LSB];
				end
				prefetch_window_pkg::OFF_W1_LO: begin
					w1_lo_nxt = reg_wdata;
				end
				prefetch_window_pkg::OFF_W1_HI: begin
					w1_hi_nxt = reg_wdata;
				end
				prefetch_window_pkg::OFF_W1_CTL: begin
					w1_ctl_nxt = reg_wdata;
				end
				prefetch_window_pkg::OFF_W2_LO: begin
					w2_lo_nxt = reg_wdata;
				end
				prefetch_window_pkg::OFF_W2_HI: begin
					w2_hi_nxt = reg_wdata;
				end
				prefetch_window_pkg::OFF_W2_SIZE: begin
					w2_size_nxt = reg_wdata;
				end
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				prefetch_window_pkg::OFF_MODE: begin
					rdata_nxt[prefetch_window_pkg::MODE_MSB:
						prefetch_window_pkg::MODE_LSB] = mode_r;
				end
				prefetch_window_pkg::OFF_W1_LO:   rdata_nxt = w1_lo_r;
				prefetch_window_pkg::OFF_W1_HI:   rdata_nxt = w1_hi_r;
				prefetch_window_pkg::OFF_W1_CTL:  rdata_nxt = w1_ctl_r;
				prefetch_window_pkg::OFF_W2_LO:   rdata_nxt = w2_lo_r;
				prefetch_window_pkg::OFF_W2_HI:   rdata_nxt = w2_hi_r;
				prefetch_window_pkg::OFF_W2_SIZE: rdata_nxt = w2_size_r;
				prefetch_window_pkg::OFF_STATUS: begin
					rdata_nxt[prefetch_window_pkg::ST_OK_BIT] = last_ok_r;
					rdata_nxt[prefetch_window_pkg::ST_W1_BIT] = last_w1_r;
					rdata_nxt[prefetch_window_pkg::ST_W2_BIT] = last_w2_r;
					rdata_nxt[prefetch_window_pkg::ST_CNT_MSB:
						prefetch_window_pkg::ST_CNT_LSB] = grant_cnt_r;
				end
				default: begin
					rdata_nxt = 32'h00000000;
				end
			endcase
		end
		active_nxt = (mode_nxt != 4'h0);
	end

	// Decision pipeline and status
	always_comb begin
		valid_nxt     = rd_req;
		ok_nxt        = 1'b0;
		hit1_nxt      = 1'b0;
		hit2_nxt      = 1'b0;
		last_ok_nxt   = last_ok_r;
		last_w1_nxt   = last_w1_r;
		last_w2_nxt   = last_w2_r;
		grant_cnt_nxt = grant_cnt_r;
		// Status write clears the grant count
		if (reg_wr && (reg_addr == prefetch_window_pkg::OFF_STATUS)) begin
			grant_cnt_nxt = prefetch_window_pkg::RST_CNT;
		end
		if (rd_req) begin
			hit1_nxt    = hit1;
			hit2_nxt    = hit2;
			ok_nxt      = active_r && permit;
			last_ok_nxt = active_r && permit;
			last_w1_nxt = hit1;
			last_w2_nxt = hit2;
			// A grant in the clearing cycle still counts
			if (active_r && permit) begin
				if (reg_wr &&
					(reg_addr == prefetch_window_pkg::OFF_STATUS)) begin
					grant_cnt_nxt = 16'h0001;
				end else begin
					grant_cnt_nxt = grant_cnt_r + 16'h0001;
				end
			end
		end
	end

	// State registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			w1_lo_r     <= prefetch_window_pkg::RST_WORD;
			w1_hi_r     <= prefetch_window_pkg::RST_WORD;
			w1_ctl_r    <= prefetch_window_pkg::RST_WORD;
			w2_lo_r     <= prefetch_window_pkg::RST_WORD;
			w2_hi_r     <= prefetch_window_pkg::RST_WORD;
			w2_size_r   <= prefetch_window_pkg::RST_WORD;
			mode_r      <= prefetch_window_pkg::RST_MODE;
			active_r    <= 1'b0;
			rdata_r     <= prefetch_window_pkg::RST_WORD;
			valid_r     <= 1'b0;
			ok_r        <= 1'b0;
			hit1_r      <= 1'b0;
			hit2_r      <= 1'b0;
			last_ok_r   <= 1'b0;
			last_w1_r   <= 1'b0;
			last_w2_r   <= 1'b0;
			grant_cnt_r <= prefetch_window_pkg::RST_CNT;
		end else begin
			w1_lo_r     <= w1_lo_nxt;
			w1_hi_r     <= w1_hi_nxt;
			w1_ctl_r    <= w1_ctl_nxt;
			w2_lo_r     <= w2_lo_nxt;
			w2_hi_r     <= w2_hi_nxt;
			w2_size_r   <= w2_size_nxt;
			mode_r      <= mode_nxt;
			active_r    <= active_nxt;
			rdata_r     <= rdata_nxt;
			valid_r     <= valid_nxt;
			ok_r        <= ok_nxt;
			hit1_r      <= hit1_nxt;
			hit2_r      <= hit2_nxt;
			last_ok_r   <= last_ok_nxt;
			last_w1_r   <= last_w1_nxt;
			last_w2_r   <= last_w2_nxt;
			grant_cnt_r <= grant_cnt_nxt;
		end
	end

	// Outputs straight from flops
	assign reg_rdata       = rdata_r;
	assign dec_valid       = valid_r;
	assign dec_prefetch_ok = ok_r;
	assign dec_window1_hit = hit1_r;
	assign dec_window2_hit = hit2_r;
	assign prefetch_mode   = mode_r;
	assign prefetch_active = active_r;

	// Window 1 low base takes the written word
	w1_lo_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == prefetch_window_pkg::OFF_W1_LO
		|=> w1_lo_r == $past(reg_wdata))
		else $error("window 1 low base not written");

	// Window 1 high base readback two cycles after write
	w1_hi_readback_a: assert property (@(posedge clk)
		disable iff (sys_rst)
		reg_wr && reg_addr == prefetch_window_pkg::OFF_W1_HI
		// Strobes never overlap, so the read follows cleanly
		##1 reg_rd && !reg_wr
		&& reg_addr == prefetch_window_pkg::OFF_W1_HI
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("window 1 high base readback wrong");

	// Empty size field never hits, bit 0 adds no bytes
	w1_size_gran_a: assert property (@(posedge clk) disable iff (sys_rst)
		rd_req && w1_ctl_r[31:1] == 31'h00000000 |=> !dec_window1_hit)
		else $error("window 1 size granularity wrong");

	// Polarity 0 hit is refused
	w1_barred_a: assert property (@(posedge clk) disable iff (sys_rst)
		rd_req && !w1_pol && hit1 |=> dec_valid && !dec_prefetch_ok)
		else $error("read in barring window was allowed");

	// Polarity 1 miss of both windows is refused
	only_inside_a: assert property (@(posedge clk) disable iff (sys_rst)
		rd_req && w1_pol && !hit1 && !hit2 |=> !dec_prefetch_ok)
		else $error("read outside windows was allowed");

	// Inactive mode never grants
	mode_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
		rd_req && !active_r |=> dec_valid && !dec_prefetch_ok)
		else $error("grant while prefetch mode off");

	// Window 2 size readback
	w2_size_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == prefetch_window_pkg::OFF_W2_SIZE
		|=> reg_rdata == $past(w2_size_r))
		else $error("window 2 size readback wrong");

	// Zero sized window matches nothing
	zero_size_a: assert property (@(posedge clk) disable iff (sys_rst)
		rd_req && w2_size_r == 32'h00000000 |=> !dec_window2_hit)
		else $error("zero size window matched");

	// Window 2 hit grants under polarity 1
	w2_permit_a: assert property (@(posedge clk) disable iff (sys_rst)
		rd_req && active_r && w1_pol && hit2 |=> dec_prefetch_ok)
		else $error("window 2 hit not granted");

endmodule

`default_nettype wire

// ==== testbench/read_master.sv ====
// Purpose: Bus master model issuing memory reads to the decoder
// Assumes: One request per trigger pulse from the bench
// Notes:   Idle address lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none

module read_master (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Trigger from the bench
	input  wire logic        go,
	input  wire logic [63:0] go_addr,
	// Read request to the bridge
	output logic             rd_req,
	output logic      [63:0] rd_addr
);
	// One-cycle request; scrambled address so stale values never match
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_req  <= 1'b0;
			rd_addr <= 64'h0;
		end else begin
			rd_req  <= go;
			rd_addr <= go ? go_addr : ~rd_addr;
		end
	end
endmodule

`default_nettype wire

// ==== testbench/read_prefetch_window_decode_tb.sv ====
// Purpose: Self-checking bench for the prefetch window decoder
// Assumes: Register port and read master driven on rising edges
// Notes:   Window corners and random addresses, both polarities
`timescale 1ns/10ps
`default_nettype none

module read_prefetch_window_decode_tb;
	logic        clk, sys_rst, reg_wr, reg_rd, go;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v, s1, s2;
	logic        rd_req, dec_valid, dec_prefetch_ok, pol;
	logic        dec_window1_hit, dec_window2_hit, prefetch_active;
	logic [3:0]  prefetch_mode, mode;
	logic [63:0] rd_addr, go_addr, b1, b2;
	logic [63:0] cn [8];
	logic [7:0]  offs [8];
	int          mismatches, n_checks, cyc;
	logic [2:0]  lst;
	logic [15:0] grants;
	integer      seed;

	read_master i_master (.clk(clk), .sys_rst(sys_rst), .go(go),
		.go_addr(go_addr), .rd_req(rd_req), .rd_addr(rd_addr));

	read_prefetch_window_decode i_dut (.clk(clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rd_req(rd_req),
		.rd_addr(rd_addr), .dec_valid(dec_valid),
		.dec_prefetch_ok(dec_prefetch_ok),
		.dec_window1_hit(dec_window1_hit),
		.dec_window2_hit(dec_window2_hit),
		.prefetch_mode(prefetch_mode), .prefetch_active(prefetch_active));

	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic check(input logic [63:0] got, exp, input string m);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Write then read the same word with no gap between strobes
	task automatic wrrd(input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask

	// Expected window membership
	function automatic logic hit(logic [63:0] a, b, logic [31:0] s);
		return a >= b && (a - b) < {32'h0, s};
	endfunction

	task automatic req(input logic [63:0] a);
		logic h1, h2, ok;
		h1 = hit(a, b1, s1);
		h2 = hit(a, b2, s2);
		ok = (mode != 4'h0) && (pol ? (h1 | h2) : !h1);
		lst = {h2, h1, ok};
		grants = grants + 16'(ok);
		@(posedge clk);
		go      <= 1'b1;
		go_addr <= a;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		#1 check(dec_valid, 1'b1, "valid");
		check(dec_window1_hit, h1, "hit 1");
		check(dec_window2_hit, h2, "hit 2");
		check(dec_prefetch_ok, ok, "permit");
	endtask

	// Program both windows and the mode field
	task automatic prog(input logic p, input logic [3:0] m, input logic z);
		b1 = {$random(seed), $random(seed)};
		b2 = {$random(seed), $random(seed)};
		s1 = z ? 32'h0 : $random(seed) & 32'hFFFFFFFE;
		s2 = z ? 32'h0 : $random(seed);
		pol = p;
		mode = m;
		wr(prefetch_window_pkg::OFF_W1_LO, b1[31:0]);
		wr(prefetch_window_pkg::OFF_W1_HI, b1[63:32]);
		wr(prefetch_window_pkg::OFF_W1_CTL, s1 | {31'h0, p});
		wr(prefetch_window_pkg::OFF_W2_LO, b2[31:0]);
		wr(prefetch_window_pkg::OFF_W2_HI, b2[63:32]);
		wr(prefetch_window_pkg::OFF_W2_SIZE, s2);
		wr(prefetch_window_pkg::OFF_MODE, {24'h0, m, 4'h0});
		#1 check(prefetch_mode, m, "mode");
		check(prefetch_active, m != 4'h0, "active");
	endtask

	initial begin
		offs = '{prefetch_window_pkg::OFF_W1_LO, prefetch_window_pkg::OFF_W1_HI,
			prefetch_window_pkg::OFF_W1_CTL, prefetch_window_pkg::OFF_W2_LO,
			prefetch_window_pkg::OFF_W2_HI, prefetch_window_pkg::OFF_W2_SIZE,
			prefetch_window_pkg::OFF_MODE, 8'h4C};
		{reg_wr, reg_rd, go, reg_addr, reg_wdata, go_addr} = '0;
		seed = 12349;
		grants = 16'h0000;
		lst = 3'h0;
		sys_rst = 1'b1;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		// Reset values, then write and read back; last is unmapped
		for (int i = 0; i < 8; i++) begin
			rd(offs[i], v);
			check(v, 32'h0, "reset value");
		end
		for (int i = 0; i < 8; i++) begin
			s1 = $random(seed);
			wrrd(offs[i], s1, v);
			s2 = (i == 6) ? s1 & 32'hF0 : (i == 7) ? 32'h0 : s1;
			check(v, s2, "read back");
		end
		// Both polarities, mode off and on, zero-size windows last
		for (int k = 0; k < 6; k++) begin
			prog(k[0], (k < 2) ? 4'h0 : 4'(k * 3), k == 5);
			cn = '{b1, b1 - 1, b1 + s1 - 1, b1 + s1,
				b2, b2 - 1, b2 + s2 - 1, b2 + s2};
			for (int j = 0; j < 8; j++) begin
				req(cn[j]);
			end
			repeat (3) req({$random(seed), $random(seed)});
			// Status holds the last decision and the grant count
			rd(prefetch_window_pkg::OFF_STATUS, v);
			check(v, {grants, 13'h0, lst}, "status");
		end
		// Any status write clears the grant count only
		wr(prefetch_window_pkg::OFF_STATUS, 32'hFFFFFFFF);
		rd(prefetch_window_pkg::OFF_STATUS, v);
		check(v, {16'h0, 13'h0, lst}, "status clear");
		// Reset in mid-run clears the control word
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(prefetch_window_pkg::OFF_W1_CTL, v);
		check(v, 32'h0, "ctl after reset");
		check(prefetch_mode, 4'h0, "mode after reset");
		check(prefetch_active, 1'b0, "active after reset");
		rd(prefetch_window_pkg::OFF_STATUS, v);
		check(v, 32'h0, "status after reset");
		wrap_up();
	end
endmodule

`default_nettype wire
